/* File: src/t8_pkg.sv */
// constants shared by the 8-bit timer-counter files
// assumes a single 100 MHz clock and plain control ports
package t8_pkg;

  // ==========================================
  // counter limits
  localparam logic [7:0] BOTTOM = 8'h00;
  localparam logic [7:0] MAX = 8'hff;

  // ==========================================
  // waveform modes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PHASE = 2'h1;
  localparam logic [1:0] MODE_CLEAR_ON_MATCH = 2'h2;
  localparam logic [1:0] MODE_FAST = 2'h3;

  // ==========================================
  // output actions
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  // ==========================================
  // tick source selection and prescale masks
  localparam logic [2:0] SRC_STOP = 3'h0;
  localparam int PRE_W = 10;
  localparam logic [9:0] MASK_DIV1 = 10'h000;
  localparam logic [9:0] MASK_DIV8 = 10'h007;
  localparam logic [9:0] MASK_DIV32 = 10'h01f;
  localparam logic [9:0] MASK_DIV64 = 10'h03f;
  localparam logic [9:0] MASK_DIV128 = 10'h07f;
  localparam logic [9:0] MASK_DIV256 = 10'h0ff;
  localparam logic [9:0] MASK_DIV1024 = 10'h3ff;

  // ==========================================
  // control readback layout
  localparam int CTRL_ACT_LSB = 6;
  localparam int CTRL_MODE_LSB = 0;

  typedef enum logic {DIR_UP, DIR_DOWN} t8_dir_e;

endpackage

/* File: src/t8_prescaler.sv */
// tick generator: divides the core clock by the selected factor
// assumes tick_source_select is synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module t8_prescaler (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // selection
  input wire logic [2:0] tick_source_select,
  // one-cycle tick
  output logic timer_tick
);

  function automatic logic [9:0] sel_mask(input logic [2:0] sel);
    case (sel)
      3'h1: sel_mask = t8_pkg::MASK_DIV1;
      3'h2: sel_mask = t8_pkg::MASK_DIV8;
      3'h3: sel_mask = t8_pkg::MASK_DIV32;
      3'h4: sel_mask = t8_pkg::MASK_DIV64;
      3'h5: sel_mask = t8_pkg::MASK_DIV128;
      3'h6: sel_mask = t8_pkg::MASK_DIV256;
      default: sel_mask = t8_pkg::MASK_DIV1024;
    endcase
  endfunction

  logic [t8_pkg::PRE_W-1:0] pre;
  logic [9:0] mask;

  // free-running, so a new selection takes effect without restart
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pre <= '0;
    end else begin
      pre <= pre + 1'b1;
    end
  end

  assign mask = sel_mask(tick_source_select);
  assign timer_tick = (tick_source_select != t8_pkg::SRC_STOP) && ((pre & mask) == mask);

endmodule // t8_prescaler
`default_nettype wire

/* File: src/t8_wave_unit.sv */
// compare output waveform generator
// assumes count_value and direction are those before the tick edge
`timescale 1ns/1ps
`default_nettype none
module t8_wave_unit (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // configuration
  input wire logic [1:0] waveform_mode,
  input wire logic [1:0] output_action,
  // counter state
  input wire logic timer_tick,
  input wire logic count_wr,
  input wire logic [7:0] count_value,
  input wire logic [7:0] compare_eff,
  input wire logic [7:0] top_value,
  input wire t8_pkg::t8_dir_e dir,
  // waveform
  output logic wave_level
);

  logic next_wave;
  logic match;
  logic special;

  assign match = count_value == compare_eff;
  assign special = output_action[1] && (compare_eff == top_value);

  always_comb begin
    next_wave = wave_level;
    if (timer_tick && !count_wr) begin
      case (waveform_mode)
        t8_pkg::MODE_FAST: begin
          // match at max wins over the bottom action
          if (match) begin
            next_wave = output_action == t8_pkg::ACT_SET;
          end else if (count_value == t8_pkg::MAX) begin
            next_wave = output_action == t8_pkg::ACT_CLEAR;
          end
        end
        t8_pkg::MODE_PHASE: begin
          if (match && (special || dir == t8_pkg::DIR_UP)) begin
            next_wave = output_action == t8_pkg::ACT_SET;
          end else if (match) begin
            next_wave = output_action == t8_pkg::ACT_CLEAR;
          end
        end
        default: begin
          if (match) begin
            case (output_action)
              t8_pkg::ACT_TOGGLE: next_wave = !wave_level;
              t8_pkg::ACT_CLEAR: next_wave = 1'b0;
              t8_pkg::ACT_SET: next_wave = 1'b1;
              default: next_wave = wave_level;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wave_level <= 1'b0;
    end else begin
      wave_level <= next_wave;
    end
  end

endmodule // t8_wave_unit
`default_nettype wire

/* File: src/t8_timer.sv */
// 8-bit timer-counter with one compare output
// assumes all control inputs are synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module t8_timer (
  // clock and reset
  input wire logic clk,
  input wire logic reset,

  // control fields
  input wire logic [2:0] tick_source_select,
  input wire logic [1:0] waveform_mode,
  input wire logic [1:0] output_action,

  // counter access
  input wire logic count_wr,
  input wire logic [7:0] count_wdata,
  output logic [7:0] count_value,

  // compare value
  input wire logic [7:0] compare_value,

  // flags
  output logic overflow_flag,
  input wire logic overflow_clear,
  output logic compare_flag,
  input wire logic compare_clear,

  // control readback
  output logic [7:0] timer_control_a,

  // port pin
  input wire logic pin_dir_out,
  input wire logic port_data,
  output logic pin_out,
  output logic pin_oe
);

  // ==========================================
  // internal signals

  logic timer_tick;
  logic [7:0] next_count;
  t8_pkg::t8_dir_e dir;
  t8_pkg::t8_dir_e next_dir;
  logic [7:0] top_value;
  logic [7:0] cmp_buf;
  logic [7:0] compare_eff;
  logic is_pwm;
  logic at_top;
  logic at_bottom;
  logic ovf_event;
  logic cmp_event;
  logic wave_level;
  logic wave_connected;

  // ==========================================
  // tick generation

  t8_prescaler u_pre (
    .clk(clk),
    .reset(reset),
    .tick_source_select(tick_source_select),
    .timer_tick(timer_tick)
  );

  // ==========================================
  // top, bottom and compare selection

  assign is_pwm = waveform_mode == t8_pkg::MODE_FAST || waveform_mode == t8_pkg::MODE_PHASE;

  // only clear-on-match takes its top from the compare value
  assign top_value = (waveform_mode == t8_pkg::MODE_CLEAR_ON_MATCH) ? compare_value : t8_pkg::MAX;

  assign at_top = count_value == top_value;
  assign at_bottom = count_value == t8_pkg::BOTTOM;

  // pwm modes reload the compare at top so a period never sees a
  // half-written value; clear-on-match uses the live value
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmp_buf <= t8_pkg::BOTTOM;
    end else if (!is_pwm || (timer_tick && at_top)) begin
      cmp_buf <= compare_value;
    end
  end

  assign compare_eff = is_pwm ? cmp_buf : compare_value;

  // ==========================================
  // counting

  always_comb begin
    next_count = count_value;
    next_dir = t8_pkg::DIR_UP;
    if (count_wr) begin
      next_count = count_wdata;
      next_dir = dir;
    end else if (timer_tick) begin
      case (waveform_mode)
        t8_pkg::MODE_CLEAR_ON_MATCH: begin
          // a top written below the count is passed by and only
          // caught again after the wrap through max
          if (at_top) begin
            next_count = t8_pkg::BOTTOM;
          end else begin
            next_count = count_value + 8'h01;
          end
        end
        t8_pkg::MODE_FAST: begin
          if (count_value == t8_pkg::MAX) begin
            next_count = t8_pkg::BOTTOM;
          end else begin
            next_count = count_value + 8'h01;
          end
        end
        t8_pkg::MODE_PHASE: begin
          next_dir = dir;
          if (dir == t8_pkg::DIR_UP && at_top) begin
            next_dir = t8_pkg::DIR_DOWN;
          end else if (dir == t8_pkg::DIR_DOWN && at_bottom) begin
            next_dir = t8_pkg::DIR_UP;
          end
          if (next_dir == t8_pkg::DIR_UP) begin
            next_count = count_value + 8'h01;
          end else begin
            next_count = count_value - 8'h01;
          end
        end
        default: begin
          next_count = count_value + 8'h01;
        end
      endcase
    end else if (waveform_mode == t8_pkg::MODE_PHASE) begin
      next_dir = dir;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_value <= t8_pkg::BOTTOM;
    end else begin
      count_value <= next_count;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dir <= t8_pkg::DIR_UP;
    end else begin
      dir <= next_dir;
    end
  end

  // ==========================================
  // flags

  // a cpu write replaces the count, so the tick it beat raises nothing
  always_comb begin
    if (waveform_mode == t8_pkg::MODE_PHASE) begin
      ovf_event = timer_tick && !count_wr && at_bottom && dir == t8_pkg::DIR_DOWN;
    end else begin
      ovf_event = timer_tick && !count_wr && count_value == t8_pkg::MAX;
    end
  end

  assign cmp_event = timer_tick && !count_wr && count_value == compare_eff;

  // set wins over a clear in the same cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      overflow_flag <= 1'b0;
    end else if (ovf_event) begin
      overflow_flag <= 1'b1;
    end else if (overflow_clear) begin
      overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      compare_flag <= 1'b0;
    end else if (cmp_event) begin
      compare_flag <= 1'b1;
    end else if (compare_clear) begin
      compare_flag <= 1'b0;
    end
  end

  // ==========================================
  // control readback

  always_comb begin
    timer_control_a = 8'h00;
    timer_control_a[t8_pkg::CTRL_ACT_LSB +: 2] = output_action;
    timer_control_a[t8_pkg::CTRL_MODE_LSB +: 2] = waveform_mode;
  end

  // ==========================================
  // waveform and pin

  t8_wave_unit u_wave (
    .clk(clk),
    .reset(reset),
    .waveform_mode(waveform_mode),
    .output_action(output_action),
    .timer_tick(timer_tick),
    .count_wr(count_wr),
    .count_value(count_value),
    .compare_eff(compare_eff),
    .top_value(top_value),
    .dir(dir),
    .wave_level(wave_level)
  );

  // in pwm modes only the upper action bit connects the pin
  assign wave_connected = is_pwm ? output_action[1] : (output_action != t8_pkg::ACT_OFF);

  // registered pin costs one cycle of delay behind the wave
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_out <= wave_connected ? wave_level : port_data;
      pin_oe <= pin_dir_out;
    end
  end

  // ==========================================
  // checks

  a_stop_no_tick: assert property (@(posedge clk) disable iff (reset)
    tick_source_select == t8_pkg::SRC_STOP |-> !timer_tick)
    else $error("tick while source stopped");

  a_cpu_write_wins: assert property (@(posedge clk) disable iff (reset)
    count_wr |=> count_value == $past(count_wdata))
    else $error("cpu write lost");

  a_hold_no_tick: assert property (@(posedge clk) disable iff (reset)
    !timer_tick && !count_wr |=> $stable(count_value))
    else $error("count moved without tick");

  a_ovf_wrap: assert property (@(posedge clk) disable iff (reset)
    timer_tick && !count_wr && !is_pwm && count_value == t8_pkg::MAX
    |=> overflow_flag && count_value == t8_pkg::BOTTOM)
    else $error("overflow not set on wrap");

  a_fast_clear: assert property (@(posedge clk) disable iff (reset)
    timer_tick && !count_wr && waveform_mode == t8_pkg::MODE_FAST
    && count_value == t8_pkg::MAX |=> count_value == t8_pkg::BOTTOM && overflow_flag)
    else $error("fast mode did not clear after max");

  a_cmp_flag_set: assert property (@(posedge clk) disable iff (reset)
    cmp_event |=> compare_flag)
    else $error("compare flag missed");

  a_cmp_flag_clear: assert property (@(posedge clk) disable iff (reset)
    compare_clear && !cmp_event |=> !compare_flag)
    else $error("compare flag not cleared");

  a_match_toggle: assert property (@(posedge clk) disable iff (reset)
    waveform_mode == t8_pkg::MODE_CLEAR_ON_MATCH && output_action == t8_pkg::ACT_TOGGLE
    && cmp_event |=> wave_level != $past(wave_level))
    else $error("toggle missed on match");

  a_match_clear: assert property (@(posedge clk) disable iff (reset)
    waveform_mode == t8_pkg::MODE_CLEAR_ON_MATCH && timer_tick && !count_wr
    && count_value == compare_value |=> count_value == t8_pkg::BOTTOM)
    else $error("count not cleared on match");

  a_match_miss: assert property (@(posedge clk) disable iff (reset)
    waveform_mode == t8_pkg::MODE_CLEAR_ON_MATCH && timer_tick && !count_wr
    && count_value > compare_value && count_value != t8_pkg::MAX
    |=> count_value == $past(count_value) + 8'h01)
    else $error("count above compare did not advance");

  a_fast_bottom_act: assert property (@(posedge clk) disable iff (reset)
    waveform_mode == t8_pkg::MODE_FAST && timer_tick && !count_wr && output_action[1]
    && count_value == t8_pkg::MAX && compare_eff != t8_pkg::MAX
    |=> wave_level == ($past(output_action) == t8_pkg::ACT_CLEAR))
    else $error("fast mode bottom action missed");

  a_fast_match_act: assert property (@(posedge clk) disable iff (reset)
    waveform_mode == t8_pkg::MODE_FAST && timer_tick && !count_wr && output_action[1]
    && count_value == compare_eff |=> wave_level == ($past(output_action) == t8_pkg::ACT_SET))
    else $error("fast mode match action missed");

  a_phase_turn: assert property (@(posedge clk) disable iff (reset)
    waveform_mode == t8_pkg::MODE_PHASE && timer_tick && !count_wr
    && dir == t8_pkg::DIR_UP && count_value == t8_pkg::MAX
    |=> count_value == t8_pkg::MAX - 8'h01 && dir == t8_pkg::DIR_DOWN)
    else $error("dual slope did not turn at top");

  a_phase_bottom: assert property (@(posedge clk) disable iff (reset)
    waveform_mode == t8_pkg::MODE_PHASE && timer_tick && !count_wr
    && dir == t8_pkg::DIR_DOWN && count_value == t8_pkg::BOTTOM
    |=> count_value == t8_pkg::BOTTOM + 8'h01 && dir == t8_pkg::DIR_UP && overflow_flag)
    else $error("dual slope did not turn at bottom");

  a_phase_down_act: assert property (@(posedge clk) disable iff (reset)
    waveform_mode == t8_pkg::MODE_PHASE && timer_tick && !count_wr && output_action[1]
    && dir == t8_pkg::DIR_DOWN && count_value == compare_eff && compare_eff != t8_pkg::MAX
    |=> wave_level == ($past(output_action) == t8_pkg::ACT_CLEAR))
    else $error("dual slope down match action missed");

  a_pin_gated: assert property (@(posedge clk) disable iff (reset)
    !pin_dir_out |=> !pin_oe)
    else $error("pin driven while input");

  a_pin_follows: assert property (@(posedge clk) disable iff (reset)
    pin_dir_out |=> pin_oe)
    else $error("pin not driven while output");

  a_pwm_port_pass: assert property (@(posedge clk) disable iff (reset)
    is_pwm && !output_action[1] |=> pin_out == $past(port_data))
    else $error("disconnected pwm pin lost port value");

  a_reserved_zero: assert property (@(posedge clk) disable iff (reset)
    timer_control_a[5:2] == 4'h0)
    else $error("reserved control bits nonzero");

endmodule // t8_timer
`default_nettype wire

/* File: verification/t8_pin_model.sv */
// pad model at the far side of the compare output
// assumes pin_oe high means the timer drives the pad
`timescale 1ns/1ps
`default_nettype none
module t8_pin_model (
  // timer side
  input wire logic pin_out,
  input wire logic pin_oe,
  // pad
  output logic pad
);
  // a released pad goes to its pull-up, never the last driven value
  assign pad = pin_oe ? pin_out : 1'b1;
endmodule // t8_pin_model
`default_nettype wire

/* File: verification/t8_timer_tb_top.sv */
// self-checking bench for the 8-bit timer-counter
// assumes the pin model is compiled before this file
`timescale 1ns/1ps
`default_nettype none
module t8_timer_tb_top;
  // ======
  // signals
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] sel = 3'h0;
  logic [1:0] mode = 2'h0;
  logic [1:0] act = 2'h0;
  logic wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] cmp = 8'h80;
  logic ovf_clr = 1'b0;
  logic cmp_clr = 1'b0;
  logic dir_out = 1'b0;
  logic port_d = 1'b0;
  logic [7:0] count;
  logic [7:0] ctrl;
  logic ovf, cf, pin, oe, pad;
  int mismatches = 0;
  int n_compared = 0;

  t8_timer dut (.clk(clk), .reset(reset), .tick_source_select(sel), .waveform_mode(mode),
    .output_action(act), .count_wr(wr), .count_wdata(wdata), .count_value(count),
    .compare_value(cmp), .overflow_flag(ovf), .overflow_clear(ovf_clr), .compare_flag(cf),
    .compare_clear(cmp_clr), .timer_control_a(ctrl), .pin_dir_out(dir_out),
    .port_data(port_d), .pin_out(pin), .pin_oe(oe));
  t8_pin_model pad_model (.pin_out(pin), .pin_oe(oe), .pad(pad));

  initial begin
    forever #5 clk = ~clk;
  end

  // ======
  // helpers
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic put(input logic [7:0] v);
    wr = 1'b1;
    wdata = v;
    step();
    wr = 1'b0;
  endtask

  // cycles until count_value next moves; bounded so a dead tick cannot hang
  task automatic gap(output int n);
    logic [7:0] c0;
    c0 = count;
    n = 0;
    while (count === c0) begin
      step();
      n++;
      if (n > 2100) begin
        mismatches++;
        tally_and_finish();
      end
    end
  endtask

  function automatic logic [7:0] nxt(input logic [1:0] m, input logic [7:0] c, input logic [7:0] k);
    return (m == t8_pkg::MODE_CLEAR_ON_MATCH && c == k) ? t8_pkg::BOTTOM : c + 8'h01;
  endfunction

  function automatic int div(input logic [2:0] s);
    int f[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    return f[s];
  endfunction

  // ======
  // tests
  initial begin
    int r;
    int n;
    logic [7:0] c;
    logic e;
    r = $urandom(50);
    step(16);
    reset = 1'b0;
    for (int i = 0; i < 16; i++) begin
      {act, mode} = 4'(i);
      step();
      chk("control", ctrl, {act, 4'h0, mode});
    end
    $display("readback done");
    mode = t8_pkg::MODE_NORMAL;
    act = t8_pkg::ACT_OFF;
    put(8'h33);
    chk("count write", count, 8'h33);
    step(20);
    chk("stopped count", count, 8'h33);
    $display("stop done");
    for (int s = 1; s < 8; s++) begin
      sel = 3'(s);
      gap(n);
      gap(n);
      chk("tick gap", n, div(3'(s)));
    end
    $display("prescale done");
    sel = 3'h1;
    ovf_clr = 1'b1;
    cmp_clr = 1'b1;
    put(8'hfe);
    ovf_clr = 1'b0;
    cmp_clr = 1'b0;
    chk("write wins", count, 8'hfe);
    step();
    chk("overflow early", ovf, 1'b0);
    step();
    chk("wrap", count, 8'h00);
    chk("overflow", ovf, 1'b1);
    $display("overflow done");
    repeat (6) begin
      r = $urandom_range(0, 2);
      mode = (r == 0) ? t8_pkg::MODE_NORMAL : (r == 1) ? t8_pkg::MODE_CLEAR_ON_MATCH : t8_pkg::MODE_FAST;
      cmp = 8'($urandom);
      c = 8'($urandom);
      put(c);
      repeat (40) begin
        c = nxt(mode, c, cmp);
        step();
        chk("count", count, c);
      end
    end
    $display("random count done");
    mode = t8_pkg::MODE_CLEAR_ON_MATCH;
    cmp = 8'h05;
    ovf_clr = 1'b1;
    cmp_clr = 1'b1;
    put(8'h10);
    ovf_clr = 1'b0;
    cmp_clr = 1'b0;
    step(245);
    chk("missed match", count, 8'h05);
    chk("match mode overflow", ovf, 1'b1);
    chk("compare early", cf, 1'b0);
    step();
    chk("match clear", count, 8'h00);
    chk("compare flag", cf, 1'b1);
    $display("match mode done");
    cmp = 8'h00;
    act = t8_pkg::ACT_TOGGLE;
    dir_out = 1'b1;
    put(8'h00);
    step(2);
    repeat (8) begin
      e = !pin;
      step();
      chk("toggle", pin, e);
      chk("pad", pad, pin);
    end
    dir_out = 1'b0;
    step();
    chk("pin released", oe, 1'b0);
    chk("pad pulled", pad, 1'b1);
    // compare zero matches on every tick, so set and clear show at once
    act = t8_pkg::ACT_SET;
    step(2);
    chk("set on match", pin, 1'b1);
    act = t8_pkg::ACT_CLEAR;
    step(2);
    chk("clear on match", pin, 1'b0);
    $display("toggle done");
    cmp = 8'h80;
    step();
    mode = t8_pkg::MODE_FAST;
    for (int a = 0; a < 4; a++) begin
      act = 2'(a);
      port_d = 1'($urandom);
      put(8'hf0);
      step(8'h50);
      e = (a < 2) ? port_d : (a == 2);
      chk("pwm after bottom", pin, e);
      step(8'h60);
      e = (a < 2) ? port_d : (a == 3);
      chk("pwm after match", pin, e);
    end
    // compare at top with the clear action gives a steady low
    cmp = 8'hff;
    act = t8_pkg::ACT_CLEAR;
    put(8'h00);
    step(600);
    chk("top compare", pin, 1'b0);
    step(100);
    chk("top compare", pin, 1'b0);
    $display("fast pwm done");
    mode = t8_pkg::MODE_NORMAL;
    cmp = 8'h80;
    reset = 1'b1;
    step();
    reset = 1'b0;
    mode = t8_pkg::MODE_PHASE;
    put(8'hfe);
    step();
    chk("up to top", count, 8'hff);
    step();
    chk("turn at top", count, 8'hfe);
    step(142);
    chk("down count", count, 8'h70);
    chk("down match", pin, 1'b1);
    step(112);
    chk("bottom", count, 8'h00);
    step();
    chk("turn at bottom", count, 8'h01);
    chk("dual overflow", ovf, 1'b1);
    step(8'h8f);
    chk("up match", pin, 1'b0);
    $display("dual slope done");
    tally_and_finish();
  end
endmodule // t8_timer_tb_top
`default_nettype wire
